// ==== rtl/rsx_pkg.sv ====
package rsx_pkg;

   // ----------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned FILE_DEPTH = 32;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] FILE_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hFF;
   localparam logic [4:0] DIR_SEL_A = 5'h06;
   localparam logic [4:0] DIR_SEL_B = 5'h07;
   localparam int unsigned NIB_LO = 0;
   localparam int unsigned NIB_HI = 4;

   // ----------------------------------------------------------------
   // Operations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_ROTATE_RIGHT = 3'b001,
      OP_NIBBLE_EXCHANGE = 3'b010,
      OP_DIRECTION_LOAD = 3'b011,
      OP_XOR_IMMEDIATE = 3'b100,
      OP_XOR_REGISTER = 3'b101
   } op_e;

   typedef struct packed {
      op_e op;
      logic [4:0] addr;
      logic dest_file;
      logic [7:0] literal;
   } instr_s;

   typedef struct packed {
      logic carry;
      logic zero;
   } flags_s;

endpackage

// ==== rtl/rsx_file_reg.sv ====
`timescale 1ns/100ps
module rsx_file_reg
   import rsx_pkg::*;
#(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] q
);

   logic [7:0] q_d;

   always_comb begin
      q_d = q;
      if (ce && we) begin
         q_d = wdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST_VAL;
      end else begin
         q <= q_d;
      end
   end

endmodule

// ==== rtl/rsx_datapath.sv ====
`timescale 1ns/100ps
// Contract
// [RULE1] Rotate file register right, only carry changes
// [RULE2] Destination bit 0 accumulator, 1 file
// [RULE3] Nibble swap moves halves, no flags
// [RULE4] Direction load copies accumulator, operand six/seven
// [RULE5] XOR literal into accumulator, zero only
// [RULE6] XOR file register, routed, zero only
// [RULE7] Carry enters bit7; zero on XOR result
module rsx_datapath
   import rsx_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic instr_valid,
   input wire instr_s instr,
   output logic [7:0] acc_q,
   output flags_s flags_q,
   output logic [7:0] dir_a_q,
   output logic [7:0] dir_b_q,
   output logic [7:0] rd_data_q,
   output logic done_q
);

   // ----------------------------------------------------------------
   // File registers
   // ----------------------------------------------------------------
   logic [7:0] file_q [FILE_DEPTH];
   logic [FILE_DEPTH-1:0] file_we;
   logic [7:0] src;
   logic [7:0] result;
   logic wr_file;
   logic wr_acc;

   assign src = file_q[instr.addr];

   genvar gi;
   generate
      for (gi = 0; gi < FILE_DEPTH; gi++) begin : g_file
         rsx_file_reg #(.RST_VAL(FILE_RST)) u_reg (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .ce(ce),
            .we(file_we[gi]),
            .wdata(result),
            .q(file_q[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Result and flags
   // ----------------------------------------------------------------
   logic [7:0] acc_d, dir_a_d, dir_b_d, rd_data_d;
   flags_s flags_d;
   logic done_d;

   always_comb begin
      result = 8'h00;
      wr_file = 1'b0;
      wr_acc = 1'b0;
      file_we = '0;
      acc_d = acc_q;
      flags_d = flags_q;
      dir_a_d = dir_a_q;
      dir_b_d = dir_b_q;
      rd_data_d = rd_data_q;
      done_d = 1'b0;
      if (instr_valid) begin
         done_d = 1'b1;
         case (instr.op)
            OP_ROTATE_RIGHT: begin
               result = {flags_q.carry, src[7:1]}; // [RULE7]
               flags_d.carry = src[0]; // [RULE1]
               wr_file = instr.dest_file;
               wr_acc = !instr.dest_file;
            end
            OP_NIBBLE_EXCHANGE: begin
               result = {src[NIB_HI-1:NIB_LO], src[7:NIB_HI]}; // [RULE3]
               wr_file = instr.dest_file;
               wr_acc = !instr.dest_file;
            end
            OP_DIRECTION_LOAD: begin
               // Other operands are ignored; flags untouched
               if (instr.addr == DIR_SEL_A) dir_a_d = acc_q; // [RULE4]
               if (instr.addr == DIR_SEL_B) dir_b_d = acc_q; // [RULE4]
            end
            OP_XOR_IMMEDIATE: begin
               result = acc_q ^ instr.literal; // [RULE5]
               flags_d.zero = (result == 8'h00); // [RULE7]
               wr_acc = 1'b1;
            end
            OP_XOR_REGISTER: begin
               result = acc_q ^ src; // [RULE6]
               flags_d.zero = (result == 8'h00); // [RULE7]
               wr_file = instr.dest_file;
               wr_acc = !instr.dest_file;
            end
            default: begin
               done_d = 1'b0;
            end
         endcase
      end
      if (wr_acc) acc_d = result; // [RULE2]
      file_we[instr.addr] = wr_file; // [RULE2]
      // Held between operations so the observed value stands until the next one
      if (done_d) begin
         rd_data_d = wr_file ? result : src;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= ACC_RST;
         flags_q <= '0;
         dir_a_q <= DIR_RST;
         dir_b_q <= DIR_RST;
         rd_data_q <= 8'h00;
         done_q <= 1'b0;
      end else if (ce) begin
         acc_q <= acc_d;
         flags_q <= flags_d;
         dir_a_q <= dir_a_d;
         dir_b_q <= dir_b_d;
         rd_data_q <= rd_data_d;
         done_q <= done_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_rot_carry;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_ROTATE_RIGHT) |=>
         flags_q.carry == $past(src[0]) && flags_q.zero == $past(flags_q.zero);
   endproperty
   a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong"); // [RULE1]

   property p_rot_acc;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_ROTATE_RIGHT && !instr.dest_file) |=>
         acc_q == {$past(flags_q.carry), $past(src[7:1])};
   endproperty
   a_rot_acc: assert property (p_rot_acc) else $error("rotate result wrong"); // [RULE7]

   property p_dest_file;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.dest_file && instr.op != OP_XOR_IMMEDIATE
         && instr.op != OP_DIRECTION_LOAD && instr.op != OP_NONE) |=> $stable(acc_q);
   endproperty
   a_dest_file: assert property (p_dest_file) else $error("accumulator written for file dest"); // [RULE2]

   property p_swap;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_NIBBLE_EXCHANGE && !instr.dest_file) |=>
         acc_q == {$past(src[3:0]), $past(src[7:4])} && $stable(flags_q);
   endproperty
   a_swap: assert property (p_swap) else $error("nibble swap wrong"); // [RULE3]

   property p_dir;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_DIRECTION_LOAD && instr.addr == DIR_SEL_B) |=>
         dir_b_q == $past(acc_q) && $stable(flags_q) && $stable(acc_q);
   endproperty
   a_dir: assert property (p_dir) else $error("direction load wrong"); // [RULE4]

   property p_xlit;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_XOR_IMMEDIATE) |=>
         acc_q == ($past(acc_q) ^ $past(instr.literal)) && flags_q.zero == (acc_q == 8'h00)
         && flags_q.carry == $past(flags_q.carry);
   endproperty
   a_xlit: assert property (p_xlit) else $error("xor literal wrong"); // [RULE5]

   property p_xreg;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_XOR_REGISTER && instr.dest_file) |=>
         rd_data_q == ($past(acc_q) ^ $past(src)) && flags_q.zero == (rd_data_q == 8'h00);
   endproperty
   a_xreg: assert property (p_xreg) else $error("xor register wrong"); // [RULE6]

   property p_freeze;
      @(posedge core_clk) disable iff (!rst_n)
      !ce |=> $stable(acc_q) && $stable(flags_q) && !$changed(done_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");

   property p_rot_file;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_ROTATE_RIGHT && instr.dest_file) |=>
         file_q[$past(instr.addr)] == {$past(flags_q.carry), $past(src[7:1])} && $stable(acc_q);
   endproperty
   a_rot_file: assert property (p_rot_file) else $error("rotate file write wrong"); // [RULE2]

   property p_xreg_acc;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_XOR_REGISTER && !instr.dest_file) |=>
         acc_q == ($past(acc_q) ^ $past(src)) && flags_q.zero == (acc_q == 8'h00)
         && flags_q.carry == $past(flags_q.carry);
   endproperty
   a_xreg_acc: assert property (p_xreg_acc) else $error("xor register into accumulator wrong"); // [RULE6]

   property p_dir_a;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_DIRECTION_LOAD && instr.addr == DIR_SEL_A) |=>
         dir_a_q == $past(acc_q) && $stable(dir_b_q) && $stable(flags_q);
   endproperty
   a_dir_a: assert property (p_dir_a) else $error("first direction load wrong"); // [RULE4]

   property p_dir_other;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && instr.op == OP_DIRECTION_LOAD && instr.addr != DIR_SEL_A
         && instr.addr != DIR_SEL_B) |=> $stable(dir_a_q) && $stable(dir_b_q) && done_q;
   endproperty
   a_dir_other: assert property (p_dir_other) else $error("direction load hit wrong operand"); // [RULE4]

   // Undecoded codes must leave no trace, not even a done pulse
   property p_refused;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && instr_valid && !(instr.op inside {OP_ROTATE_RIGHT, OP_NIBBLE_EXCHANGE, OP_DIRECTION_LOAD,
         OP_XOR_IMMEDIATE, OP_XOR_REGISTER})) |=> !done_q && $stable(acc_q) && $stable(flags_q);
   endproperty
   a_refused: assert property (p_refused) else $error("unknown code had an effect");

   c_rot: cover property (@(posedge core_clk) disable iff (!rst_n)
      ce && instr_valid && instr.op == OP_ROTATE_RIGHT && instr.dest_file);
   c_zero: cover property (@(posedge core_clk) disable iff (!rst_n)
      ce && instr_valid && instr.op == OP_XOR_REGISTER ##1 flags_q.zero);
   c_dir: cover property (@(posedge core_clk) disable iff (!rst_n)
      ce && instr_valid && instr.op == OP_DIRECTION_LOAD && instr.addr == DIR_SEL_A);
   c_swap_file: cover property (@(posedge core_clk) disable iff (!rst_n)
      ce && instr_valid && instr.op == OP_NIBBLE_EXCHANGE && instr.dest_file);

endmodule

// ==== bench/rotate_swap_xor_datapath_bench.sv ====
`timescale 1ns/100ps
module rotate_swap_xor_datapath_bench;
   import rsx_pkg::*;
   // ------------------------------------------------------------
   // Stimulus, observed outputs and expected state
   // ------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic instr_valid = 1'b0;
   instr_s instr = '0;
   logic [7:0] acc_q, dir_a_q, dir_b_q, rd_data_q;
   flags_s flags_q;
   logic done_q;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   logic [7:0] m_acc = ACC_RST;
   logic [7:0] m_da = DIR_RST;
   logic [7:0] m_db = DIR_RST;
   logic m_c = 1'b0;
   logic m_z = 1'b0;
   logic [7:0] m_f [32];

   always #25 core_clk = ~core_clk;

   rsx_datapath u_rsx_datapath (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid),
      .instr(instr), .acc_q(acc_q), .flags_q(flags_q), .dir_a_q(dir_a_q), .dir_b_q(dir_b_q),
      .rd_data_q(rd_data_q), .done_q(done_q));

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Hang guard: the whole sequence needs well under a hundred cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // One instruction: drive, predict, compare the outputs, rd_data_q only after an enabled rotate, swap or XOR register
   // ------------------------------------------------------------
   task automatic run(input logic [2:0] code, input logic [4:0] a, input logic d, input logic [7:0] k,
      input logic en);
      logic [7:0] r;
      logic [7:0] old;
      logic ok;
      old = m_f[a];
      r = m_acc;
      ok = en && (code inside {[3'd1:3'd5]});
      @(posedge core_clk);
      ce <= en;
      instr_valid <= 1'b1;
      instr <= '{op: op_e'(code), addr: a, dest_file: d, literal: k};
      @(posedge core_clk);
      instr_valid <= 1'b0;
      ce <= 1'b1;
      #1;
      if (ok) begin
         case (code)
            3'd1: begin
               r = {m_c, old[7:1]};
               m_c = old[0];
            end
            3'd2: r = {old[3:0], old[7:4]};
            3'd3: begin
               if (a == DIR_SEL_A) m_da = m_acc;
               if (a == DIR_SEL_B) m_db = m_acc;
            end
            3'd4: begin
               m_acc = m_acc ^ k;
               m_z = (m_acc == 8'h00);
            end
            default: begin
               r = m_acc ^ old;
               m_z = (r == 8'h00);
            end
         endcase
         if (code inside {3'd1, 3'd2, 3'd5}) begin
            if (d) m_f[a] = r;
            else m_acc = r;
            chk("rd_data_q", rd_data_q, d ? r : old);
         end
      end
      chk("acc_q", acc_q, m_acc);
      chk("carry", {7'h00, flags_q.carry}, {7'h00, m_c});
      chk("zero", {7'h00, flags_q.zero}, {7'h00, m_z});
      chk("dir_a_q", dir_a_q, m_da);
      chk("dir_b_q", dir_b_q, m_db);
      chk("done_q", {7'h00, done_q}, {7'h00, ok});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Reset state and unknown codes do nothing
   task automatic t_idle_codes;
      run(3'd0, 5'd0, 1'b0, 8'h00, 1'b1);
      run(3'd6, 5'd1, 1'b1, 8'h11, 1'b1);
      run(3'd7, 5'd2, 1'b0, 8'h22, 1'b1);
   endtask

   // Seed file registers at both address limits
   task automatic t_xor_seed;
      run(3'd4, 5'd0, 1'b0, 8'hA5, 1'b1);
      run(3'd5, 5'd31, 1'b1, 8'h00, 1'b1);
      run(3'd4, 5'd0, 1'b1, 8'hA5, 1'b1);
      run(3'd4, 5'd0, 1'b0, 8'h3C, 1'b1);
      run(3'd5, 5'd0, 1'b1, 8'h00, 1'b1);
   endtask

   // Rotates with carry clear and set, both destinations
   task automatic t_rotate_swap;
      run(3'd1, 5'd31, 1'b1, 8'h00, 1'b1);
      run(3'd1, 5'd31, 1'b0, 8'h00, 1'b1);
      run(3'd2, 5'd0, 1'b0, 8'h00, 1'b1);
      run(3'd2, 5'd0, 1'b1, 8'h00, 1'b1);
      run(3'd5, 5'd0, 1'b0, 8'h00, 1'b1);
   endtask

   // Zero flag must survive a rotate and a swap
   task automatic t_flags_hold;
      run(3'd1, 5'd0, 1'b1, 8'h00, 1'b1);
      run(3'd2, 5'd31, 1'b1, 8'h00, 1'b1);
   endtask

   task automatic t_direction;
      run(3'd4, 5'd0, 1'b0, 8'h5A, 1'b1);
      run(3'd3, 5'd6, 1'b0, 8'h00, 1'b1);
      run(3'd4, 5'd0, 1'b0, 8'hFF, 1'b1);
      run(3'd3, 5'd7, 1'b0, 8'h00, 1'b1);
      run(3'd3, 5'd5, 1'b0, 8'h00, 1'b1);
   endtask

   // Clock enable low freezes everything
   task automatic t_freeze;
      run(3'd4, 5'd0, 1'b0, 8'hFF, 1'b0);
      run(3'd5, 5'd31, 1'b0, 8'h00, 1'b1);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      for (int i = 0; i < 32; i++)
         m_f[i] = FILE_RST;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      t_idle_codes();
      t_xor_seed();
      t_rotate_swap();
      t_flags_hold();
      t_direction();
      t_freeze();
      report_and_stop();
   end
endmodule
